/* File: rtl/diag_record_pkg.sv */
// Purpose: Shared constants and carriers for the analog input diagnostic record
// Assumes: One 25 MHz clock, synchronous active-high reset
// Notes:   Byte positions are offsets inside the record, not bus addresses
package diag_record_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_PERIOD_NS = 1000;
    localparam int CYC_PER_US = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [31:0] TICKER_RESET = 32'h0000_0000;

    // ==========================================================
    // Record set numbers and lengths
    localparam logic [7:0] REC_FULL = 8'h01;
    localparam logic [7:0] REC_SHORT = 8'h00;
    localparam logic [4:0] REC_FULL_LEN = 5'h14;
    localparam logic [4:0] REC_SHORT_LEN = 5'h04;

    // ==========================================================
    // Byte positions inside the record
    localparam logic [4:0] POS_SUMMARY = 5'h00;
    localparam logic [4:0] POS_CLASS = 5'h01;
    localparam logic [4:0] POS_RSVD = 5'h02;
    localparam logic [4:0] POS_EXTRA = 5'h03;
    localparam logic [4:0] POS_CHKIND = 5'h04;
    localparam logic [4:0] POS_DIAG_BITS_PER_CHANNEL = 5'h05;
    localparam logic [4:0] POS_CHANNEL_COUNT = 5'h06;
    localparam logic [4:0] POS_GROUP = 5'h07;
    localparam logic [4:0] POS_CH0 = 5'h08;
    localparam logic [4:0] POS_UNUSED = 5'h0c;
    localparam logic [4:0] POS_STAMP = 5'h10;

    // ==========================================================
    // Fixed record contents and reset values
    localparam logic [3:0] CLASS_ANALOG = 4'h5;
    localparam logic [7:0] CLASS_RESET = 8'h15;
    localparam logic [6:0] CHKIND_AIN = 7'h71;
    localparam logic [7:0] DIAG_BITS_PER_CHANNEL_VAL = 8'h08;
    localparam logic [7:0] CHANNEL_COUNT_VAL = 8'h04;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // ==========================================================
    // Field positions
    localparam int SUM_FAIL = 0;
    localparam int SUM_INT = 1;
    localparam int SUM_EXT = 2;
    localparam int SUM_CHAN = 3;
    localparam int SUM_AUX = 4;
    localparam int SUM_PARAM = 7;
    localparam int CLASS_CHINFO = 4;
    localparam int EXTRA_BUFOVF = 3;
    localparam int EXTRA_COMM = 4;
    localparam int EXTRA_LOST = 6;
    localparam int CHF_PARAM = 0;
    localparam int CHF_LOST = 5;
    localparam int CHF_UNDER = 6;
    localparam int CHF_OVER = 7;

    // Error sources of one channel
    typedef struct packed {
        logic param_err;
        logic irq_lost;
        logic under;
        logic over;
    } chan_err_s;

    // Module-wide error sources
    typedef struct packed {
        logic param_err;
        logic fail;
        logic internal;
        logic external;
        logic aux_missing;
        logic buf_ovf;
        logic comm_err;
        logic irq_lost;
    } mod_err_s;

endpackage

/* File: rtl/us_ticker.sv */
// Purpose: Free-running 32-bit microsecond counter
// Assumes: Clock period divides the microsecond closely enough
// Notes:   Wraps naturally after the all-ones count
`timescale 1ns/10ps
module us_ticker
    import diag_record_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // Count
    output logic [31:0]      ticks
);

    localparam logic [4:0] DIV_LAST = 5'(CYC_PER_US - 1);

    logic [4:0] div_cnt;
    logic       us_en;

    // ==========================================================
    // Divider: one-cycle enable per microsecond
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || us_en)
            div_cnt <= 5'h00;
        else
            div_cnt <= div_cnt + 5'h01;
    end

    assign us_en = (div_cnt == DIV_LAST);

    // Counter from zero at reset, rolls over to zero
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            ticks <= TICKER_RESET;
        else if (us_en)
            ticks <= ticks + 32'h0000_0001;
    end

endmodule

/* File: rtl/diag_window.sv */
// Purpose: Incoming/going tracking for one diagnostic source
// Assumes: Flag inputs are on core_clk
// Notes:   Flags freeze while the window is open
`timescale 1ns/10ps
module diag_window
    import diag_record_pkg::*;
#(
    parameter int W = 8
)
(
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         sys_rst,
    // Source
    input  wire logic         enable,
    input  wire logic [W-1:0] flags,
    // Result
    output logic              active,
    output logic [W-1:0]      held,
    output logic              incoming,
    output logic              going
);

    logic cause;

    assign cause = enable && (flags != '0);

    // Window open from cause until it disappears
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            active <= 1'b0;
        else
            active <= cause;
    end

    // Snapshot only at the opening; later events are dropped
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            held <= '0;
        else if (cause && !active)
            held <= flags;
        else if (!cause)
            held <= '0;
    end

    assign incoming = cause && !active;
    assign going = !cause && active;

endmodule

/* File: rtl/analog_input_diag_record.sv */
// Purpose: Diagnostic record and timestamps of a four-channel analog input module
// Assumes: All error sources come from logic on core_clk
// Notes:   Record read answers one cycle after the request
//
// What this block does
// - 32-bit microsecond counter starts at zero, wraps to zero.
// - Hardware interrupt timestamp holds counter low 16 bits at the event.
// - Diagnostic interrupts only when enabled by parameters.
// - Incoming interrupt on cause, going interrupt automatically when cause clears.
// - Events on a channel inside its open window are discarded.
// - Fault indicator on from first incoming until last going.
// - Full record as set 01h; first four bytes as set 00h.
// - Summary byte: bits 0,1,2,3,4,7 for the module error kinds.
// - Class byte: 0101b in bits 3..0, bit 4 channel info present.
// - Extra byte: bit 3 buffer overflow, 4 communication, 6 lost interrupt.
// - Channel type byte reads analog input code 71h, bit 7 reserved.
// - Diagnostic bits per channel byte reads 08h.
// - Channel count byte reads 04h.
// - Group error byte bit n for channel group n, upper bits zero.
// - Channel byte: bit 0 parameter, 5 lost, 6 underflow, 7 overflow.
// - Four-byte diagnostic timestamp holds full counter at the diagnostic.
`timescale 1ns/10ps
module analog_input_diag_record
    import diag_record_pkg::*;
#(
    parameter int NCH = 4
)
(
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    // Parameterisation
    input  wire logic              diag_irq_enable,
    // Error sources
    input  wire chan_err_s [NCH-1:0] chan_err,
    input  wire mod_err_s          mod_err,
    input  wire logic              hw_irq_event,
    // Record read port
    input  wire logic              rec_rd,
    input  wire logic [7:0]        record_set_number,
    input  wire logic [4:0]        rec_byte,
    output logic [7:0]             rec_data,
    output logic                   rec_valid,
    output logic                   rec_err,
    // Interrupts and indicator
    output logic                   diag_irq_incoming,
    output logic                   diag_irq_going,
    output logic                   module_fault_indicator,
    output logic [15:0]            interrupt_time_low,
    output logic [31:0]            diag_timestamp
);

    logic [31:0]      ticks;
    // Window tracker results
    logic [NCH-1:0]   ch_active;
    logic [NCH-1:0]   ch_inc;
    logic [NCH-1:0]   ch_go;
    logic [7:0]       ch_held [NCH];
    logic [7:0]       ch_flags [NCH];
    logic             mod_active;
    logic             mod_inc;
    logic             mod_go;
    logic [7:0]       mod_held;
    logic             any_inc;
    logic             any_go;
    // Record bytes, built from the snapshots or fixed
    logic [7:0]       module_diag_summary;
    logic [7:0]       module_class_info;
    logic [7:0]       extra_diag_flags;
    logic [7:0]       channel_kind_code;
    logic [7:0]       channel_group_faults;
    logic             chan_any;
    logic             param_any;
    // Read path
    logic [7:0]       next_rec_data;
    logic             next_rec_err;

    // ==========================================================
    // Microsecond ticker
    // Shared by both timestamps so they agree on one moment
    us_ticker i_us_ticker
    (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .ticks    (ticks)
    );

    // ==========================================================
    // Hardware interrupt timestamp
    // Only the low half fits the two-byte field
    // Only the latest event is kept; an unread older stamp is overwritten
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            interrupt_time_low <= 16'h0000;
        else if (hw_irq_event)
            interrupt_time_low <= ticks[15:0];
    end

    // ==========================================================
    // Per-channel flag bytes, reserved bits tied low
    // Bits 4..1 stay zero, a channel has no such causes
    always_comb
    begin
        for (int i = 0; i < NCH; i++)
        begin
            ch_flags[i] = BYTE_RESET;
            ch_flags[i][CHF_PARAM] = chan_err[i].param_err;
            ch_flags[i][CHF_LOST] = chan_err[i].irq_lost;
            ch_flags[i][CHF_UNDER] = chan_err[i].under;
            ch_flags[i][CHF_OVER] = chan_err[i].over;
        end
    end

    // One window tracker per channel
    // Each channel closes on its own; a busy channel cannot mask another
    for (genvar g = 0; g < NCH; g++)
    begin : g_chan
        diag_window #(.W(8)) i_diag_window
        (
            .core_clk (core_clk),
            .sys_rst  (sys_rst),
            .enable   (diag_irq_enable),
            .flags    (ch_flags[g]),
            .active   (ch_active[g]),
            .held     (ch_held[g]),
            .incoming (ch_inc[g]),
            .going    (ch_go[g])
        );
    end

    // Module-wide causes share the same window behaviour
    diag_window #(.W(8)) i_diag_window
    (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .enable   (diag_irq_enable),
        .flags    (mod_err),
        .active   (mod_active),
        .held     (mod_held),
        .incoming (mod_inc),
        .going    (mod_go)
    );

    // ==========================================================
    // Interrupt pulses
    // Several sources in one cycle merge into one pulse
    // A going of one source and an incoming of another may share a cycle
    assign any_inc = (|ch_inc) || mod_inc;
    assign any_go = (|ch_go) || mod_go;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            diag_irq_incoming <= 1'b0;
            diag_irq_going <= 1'b0;
        end
        else
        begin
            diag_irq_incoming <= any_inc;
            diag_irq_going <= any_go;
        end
    end

    // Indicator stays on while any window is open
    // Registered from the windows, so it stays on through the going pulse
    // and drops one cycle later
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            module_fault_indicator <= 1'b0;
        else
            module_fault_indicator <= (|ch_active) || mod_active || any_inc;
    end

    // ==========================================================
    // Diagnostic timestamp, full counter at an incoming event
    // A later source overwrites it; the host sees the newest incoming
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            diag_timestamp <= TICKER_RESET;
        else if (any_inc)
            diag_timestamp <= ticks;
    end

    // ==========================================================
    // Summary and group bytes from the held snapshots
    // Derived, not stored, so they clear together with the windows
    always_comb
    begin
        chan_any = 1'b0;
        param_any = mod_held[7];
        channel_group_faults = BYTE_RESET;
        for (int i = 0; i < NCH; i++)
        begin
            channel_group_faults[i] = (ch_held[i] != BYTE_RESET);
            chan_any = chan_any || (ch_held[i] != BYTE_RESET);
            param_any = param_any || ch_held[i][CHF_PARAM];
        end
    end

    // mod_held order follows mod_err_s, param_err highest
    always_comb
    begin
        module_diag_summary = BYTE_RESET;
        module_diag_summary[SUM_FAIL] = mod_held[6];
        module_diag_summary[SUM_INT] = mod_held[5];
        module_diag_summary[SUM_EXT] = mod_held[4];
        module_diag_summary[SUM_CHAN] = chan_any;
        module_diag_summary[SUM_AUX] = mod_held[3];
        module_diag_summary[SUM_PARAM] = param_any;
    end

    // Extra byte from the module snapshot
    always_comb
    begin
        extra_diag_flags = BYTE_RESET;
        extra_diag_flags[EXTRA_BUFOVF] = mod_held[2];
        extra_diag_flags[EXTRA_COMM] = mod_held[1];
        extra_diag_flags[EXTRA_LOST] = mod_held[0];
    end

    // Fixed identity bytes
    // Constant bytes cost no flip-flops
    always_comb
    begin
        module_class_info = BYTE_RESET;
        module_class_info[3:0] = CLASS_ANALOG;
        module_class_info[CLASS_CHINFO] = 1'b1;
        channel_kind_code = {1'b0, CHKIND_AIN};
    end

    // ==========================================================
    // Record byte select
    // Unknown sets and bytes past the end answer zero with error
    // Data is live: a window that closes between reads clears its byte
    // Timestamp bytes are little-endian, byte 16 holds bits 7:0
    always_comb
    begin
        next_rec_data = BYTE_RESET;
        next_rec_err = 1'b0;
        if (record_set_number == REC_FULL)
            next_rec_err = (rec_byte >= REC_FULL_LEN);
        else if (record_set_number == REC_SHORT)
            next_rec_err = (rec_byte >= REC_SHORT_LEN);
        else
            next_rec_err = 1'b1;
        if (!next_rec_err)
        begin
            if (rec_byte == POS_SUMMARY)
                next_rec_data = module_diag_summary;
            else if (rec_byte == POS_CLASS)
                next_rec_data = module_class_info;
            else if (rec_byte == POS_RSVD)
                next_rec_data = BYTE_RESET;
            else if (rec_byte == POS_EXTRA)
                next_rec_data = extra_diag_flags;
            else if (rec_byte == POS_CHKIND)
                next_rec_data = channel_kind_code;
            else if (rec_byte == POS_DIAG_BITS_PER_CHANNEL)
                next_rec_data = DIAG_BITS_PER_CHANNEL_VAL;
            else if (rec_byte == POS_CHANNEL_COUNT)
                next_rec_data = CHANNEL_COUNT_VAL;
            else if (rec_byte == POS_GROUP)
                next_rec_data = channel_group_faults;
            else if (rec_byte >= POS_CH0 && rec_byte < POS_UNUSED)
                next_rec_data = ch_held[rec_byte[1:0]];
            else if (rec_byte >= POS_STAMP)
                next_rec_data = diag_timestamp[8*rec_byte[1:0] +: 8];
            else
                next_rec_data = BYTE_RESET;
        end
    end

    // ==========================================================
    // Read answer registers
    // Data and error hold until the next request, for a slow host
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            rec_data <= BYTE_RESET;
            rec_err <= 1'b0;
        end
        else if (rec_rd)
        begin
            rec_data <= next_rec_data;
            rec_err <= next_rec_err;
        end
    end

    // Answer strobe, one cycle after each request
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            rec_valid <= 1'b0;
        else
            rec_valid <= rec_rd;
    end

endmodule

/* File: test/analog_input_diag_record_monitor.sv */
// Purpose: Port-level checks of the diagnostic record block
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Sees only the top module ports
`timescale 1ns/10ps
module analog_input_diag_record_monitor
    import diag_record_pkg::*;
#(
    parameter int NCH = 4
)
(
    // Clock and reset
    input wire logic                 core_clk,
    input wire logic                 sys_rst,
    // Inputs
    input wire logic                 diag_irq_enable,
    input wire chan_err_s [NCH-1:0]  chan_err,
    input wire mod_err_s             mod_err,
    input wire logic                 hw_irq_event,
    input wire logic                 rec_rd,
    input wire logic [7:0]           record_set_number,
    input wire logic [4:0]           rec_byte,
    // Outputs
    input wire logic [7:0]           rec_data,
    input wire logic                 rec_valid,
    input wire logic                 rec_err,
    input wire logic                 diag_irq_incoming,
    input wire logic                 diag_irq_going,
    input wire logic                 module_fault_indicator,
    input wire logic [15:0]          interrupt_time_low,
    input wire logic [31:0]          diag_timestamp
);
    // ==========================================================
    // Defaults
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // ==========================================================
    // Read port
    property p_rd_answer;
        rec_rd |=> rec_valid;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read not answered");
    property p_valid_cause;
        rec_valid |-> $past(rec_rd);
    endproperty
    a_valid_cause: assert property (p_valid_cause)
        else $error("valid without read");
    property p_class;
        rec_rd && record_set_number == REC_FULL && rec_byte == POS_CLASS |=> rec_data == 8'h15;
    endproperty
    a_class: assert property (p_class)
        else $error("class byte wrong");
    property p_chkind;
        rec_rd && record_set_number == REC_FULL && rec_byte == POS_CHKIND |=> rec_data == 8'h71;
    endproperty
    a_chkind: assert property (p_chkind)
        else $error("channel type byte wrong");
    property p_short_err;
        rec_rd && record_set_number == REC_SHORT && rec_byte >= 5'h04 |=> rec_err && rec_data == 8'h00;
    endproperty
    a_short_err: assert property (p_short_err)
        else $error("short record past length");

    // ==========================================================
    // Diagnostic events
    property p_disabled;
        !diag_irq_enable |=> !diag_irq_incoming;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("incoming while disabled");
    property p_ind_on;
        diag_irq_incoming |-> module_fault_indicator;
    endproperty
    a_ind_on: assert property (p_ind_on)
        else $error("indicator off at incoming");
    property p_ind_off;
        $fell(module_fault_indicator) |-> $past(diag_irq_going);
    endproperty
    a_ind_off: assert property (p_ind_off)
        else $error("indicator fell without going");
    property p_stamp_hold;
        !$past(hw_irq_event) |-> $stable(interrupt_time_low);
    endproperty
    a_stamp_hold: assert property (p_stamp_hold)
        else $error("interrupt stamp moved");
    property p_diag_hold;
        $changed(diag_timestamp) |-> diag_irq_incoming;
    endproperty
    a_diag_hold: assert property (p_diag_hold)
        else $error("diag stamp moved");

    // Main scenarios reached
    c_incoming: cover property (diag_irq_incoming);
    c_going: cover property (diag_irq_going);
    c_refused: cover property (rec_valid && rec_err);
endmodule

bind analog_input_diag_record analog_input_diag_record_monitor #(.NCH(NCH)) i_analog_input_diag_record_monitor (
    .core_clk(core_clk), .sys_rst(sys_rst), .diag_irq_enable(diag_irq_enable),
    .chan_err(chan_err), .mod_err(mod_err), .hw_irq_event(hw_irq_event),
    .rec_rd(rec_rd), .record_set_number(record_set_number), .rec_byte(rec_byte),
    .rec_data(rec_data), .rec_valid(rec_valid), .rec_err(rec_err),
    .diag_irq_incoming(diag_irq_incoming), .diag_irq_going(diag_irq_going),
    .module_fault_indicator(module_fault_indicator),
    .interrupt_time_low(interrupt_time_low), .diag_timestamp(diag_timestamp));

/* File: test/record_host.sv */
// Purpose: Backplane host that reads record bytes
// Assumes: Answer comes one cycle after the request
// Notes:   Released lines show inverted values, never the last request
`timescale 1ns/10ps
module record_host
(
    // Clock
    input wire logic  core_clk,
    // Answer
    input wire logic [7:0] rec_data,
    input wire logic       rec_valid,
    input wire logic       rec_err,
    // Request
    output logic           rec_rd,
    output logic [7:0]     record_set_number,
    output logic [4:0]     rec_byte
);
    // Idle request lines
    initial
    begin
        rec_rd = 1'b0;
        record_set_number = 8'hfe;
        rec_byte = 5'h1f;
    end

    // One byte read, answer taken in the answer cycle
    task automatic read(input logic [7:0] set, input logic [4:0] idx,
                        output logic [7:0] d, output logic e, output logic ok);
        @(negedge core_clk);
        rec_rd = 1'b1;
        record_set_number = set;
        rec_byte = idx;
        @(negedge core_clk);
        rec_rd = 1'b0;
        record_set_number = ~set;
        rec_byte = ~idx;
        ok = rec_valid;
        d = rec_data;
        e = rec_err;
    endtask
endmodule

/* File: test/analog_input_diag_record_tb.sv */
// Purpose: Self-checking bench of the diagnostic record block
// Assumes: Inputs change at the falling edge
// Notes:   Tick phase follows reset release, so stamps are checked as exact counts
`timescale 1ns/10ps
module analog_input_diag_record_tb
    import diag_record_pkg::*;
;
    logic            core_clk = 1'b0;
    logic            sys_rst, diag_irq_enable, hw_irq_event;
    chan_err_s [3:0] ce;
    mod_err_s        me;
    logic            rec_rd, rec_valid, rec_err, inc, going, mfi;
    logic [7:0]      rec_data, record_set_number;
    logic [4:0]      rec_byte;
    logic [15:0]     interrupt_time_low;
    logic [31:0]     diag_timestamp;
    int              failures = 0;
    int              num_checks = 0;
    // Idle record rows, bytes past 7 read zero
    localparam logic [7:0] IDLE_REC [8] = '{8'h00, 8'h15, 8'h00, 8'h00, 8'h71, 8'h08, 8'h04, 8'h00};
    localparam logic [4:0] MPOS [8] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h03, 5'h03, 5'h03};
    localparam logic [7:0] MVAL [8] = '{8'h80, 8'h01, 8'h02, 8'h04, 8'h10, 8'h08, 8'h10, 8'h40};
    localparam logic [7:0] CVAL [4] = '{8'h01, 8'h20, 8'h40, 8'h80};

    analog_input_diag_record i_analog_input_diag_record (
        .core_clk(core_clk), .sys_rst(sys_rst), .diag_irq_enable(diag_irq_enable),
        .chan_err(ce), .mod_err(me), .hw_irq_event(hw_irq_event), .rec_rd(rec_rd),
        .record_set_number(record_set_number), .rec_byte(rec_byte), .rec_data(rec_data),
        .rec_valid(rec_valid), .rec_err(rec_err), .diag_irq_incoming(inc), .diag_irq_going(going),
        .module_fault_indicator(mfi), .interrupt_time_low(interrupt_time_low),
        .diag_timestamp(diag_timestamp));
    record_host i_record_host (.core_clk(core_clk), .rec_data(rec_data), .rec_valid(rec_valid),
        .rec_err(rec_err), .rec_rd(rec_rd), .record_set_number(record_set_number), .rec_byte(rec_byte));

    // ==========================================================
    // Clock and helpers
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic rdchk(input logic [7:0] set, input logic [4:0] idx, input logic [7:0] ed, input logic ee);
        logic [7:0] d;
        logic       e;
        logic       ok;
        i_record_host.read(set, idx, d, e, ok);
        check("rec_valid", ok, 1'b1);
        check("rec_err", e, ee);
        check("rec_data", d, ed);
    endtask

    task automatic summarize();
        if (failures == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Watchdog, run needs well under 2000 cycles
    initial
    begin
        repeat (5000) @(posedge core_clk);
        failures++;
        summarize();
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        sys_rst = 1'b1;
        diag_irq_enable = 1'b0;
        hw_irq_event = 1'b0;
        ce = '0;
        me = '0;
        step(2);
        sys_rst = 1'b0;
        hw_irq_event = 1'b1;
        step(1);
        hw_irq_event = 1'b0;
        check("time_low start", interrupt_time_low, 16'h0000);
        step(249);
        hw_irq_event = 1'b1;
        step(1);
        hw_irq_event = 1'b0;
        check("time_low 250 cycles", interrupt_time_low, 16'(250 / CYC_PER_US));
        // Idle rows of both record sets, refused bytes read zero
        for (int s = 0; s < 2; s++)
            for (int i = 0; i < 21; i++)
            begin
                logic       p;
                logic [7:0] ed;
                p = (i >= (s ? 20 : 4));
                ed = (!p && i < 8) ? IDLE_REC[i] : 8'h00;
                rdchk(8'(s), 5'(i), ed, p);
            end
        rdchk(8'h02, 5'h00, 8'h00, 1'b1);
        diag_irq_enable = 1'b1;
        // Every module error kind
        for (int i = 0; i < 8; i++)
        begin
            me = mod_err_s'(8'h80 >> i);
            step(1);
            check("incoming", inc, 1'b1);
            rdchk(REC_FULL, MPOS[i], MVAL[i], 1'b0);
            me = '0;
            step(1);
            check("going", going, 1'b1);
            step(2);
        end
        // Every channel error kind, one per channel
        for (int k = 0; k < 4; k++)
        begin
            ce[k] = chan_err_s'(4'h8 >> k);
            step(2);
            rdchk(REC_FULL, 5'(8 + k), CVAL[k], 1'b0);
            rdchk(REC_FULL, POS_GROUP, 8'(1 << k), 1'b0);
            rdchk(REC_FULL, POS_SUMMARY, (k == 0) ? 8'h88 : 8'h08, 1'b0);
            ce = '0;
            step(3);
        end
        // Open window: later event lost, stamps agree
        ce[1].over = 1'b1;
        hw_irq_event = 1'b1;
        step(1);
        hw_irq_event = 1'b0;
        check("incoming", inc, 1'b1);
        check("indicator on", mfi, 1'b1);
        check("diag stamp", diag_timestamp[15:0], interrupt_time_low);
        ce[1].under = 1'b1;
        step(1);
        check("no second incoming", inc, 1'b0);
        rdchk(REC_FULL, 5'h09, 8'h80, 1'b0);
        rdchk(REC_FULL, POS_SUMMARY, 8'h08, 1'b0);
        rdchk(REC_FULL, POS_STAMP, interrupt_time_low[7:0], 1'b0);
        check("indicator held", mfi, 1'b1);
        ce = '0;
        step(1);
        check("going", going, 1'b1);
        check("indicator through going", mfi, 1'b1);
        step(1);
        check("indicator off", mfi, 1'b0);
        rdchk(REC_FULL, 5'h09, 8'h00, 1'b0);
        // Disabled interrupts stay silent
        diag_irq_enable = 1'b0;
        ce[2].over = 1'b1;
        step(1);
        check("incoming disabled", inc, 1'b0);
        check("indicator disabled", mfi, 1'b0);
        ce = '0;
        step(2);
        summarize();
    end
endmodule
